/* File: common/drs_pkg.sv */
// Function
// - over-temp turns all rails off, restarts
// - over-temp latches fault bit 0
// - over-temp leaves other register bits alone
// - over-temp flag cleared by pin cycling
// - second fault read clears over-temp flag
// - no undervoltage faults during over-temp
// - qualified undervoltage disables the regulator
// - undervoltage shorter than 100us filtered
// - undervoltage latches bits 3, 2, 1
// - undervoltage flags cleared by pin cycling
// - boost starts on either pin, no lockout
// - positive needs its pin and soft-start
// - negative starts 2ms after later event
// - pin low shuts its rail down
// - both pins low turns everything off
// - lockout turns all rails off together
// - enable bits 1, 2 gate negative, positive
// - enable write applied at stop condition
// - 0x07 write starts positive, then negative
// - pin sequencing needs enable bits set
// - tied pins low stop both together
// - hi-z bit keeps pull-down disconnected
// - boost gated by bit 0, bits 0-2 reset one
package drs_pkg;
   localparam logic [7:0] FAULT_FLAGS_ADDR = 8'h04;
   localparam logic [7:0] RAIL_ENABLE_CONTROL_ADDR = 8'h05;
   localparam logic [7:0] FAULT_FLAGS_RST = 8'h00;
   localparam logic [7:0] RAIL_ENABLE_RST = 8'h07;
   localparam int FLT_OTP = 0;
   localparam int FLT_BOOST_UV = 1;
   localparam int FLT_NEG_UV = 2;
   localparam int FLT_POS_UV = 3;
   localparam int EN_BOOST = 0;
   localparam int EN_NEG = 1;
   localparam int EN_POS = 2;
   localparam int EN_POS_HIZ = 3;
   // arbitrary bus address
   localparam logic [6:0] I2C_DEV_ADDR = 7'h2A;
   localparam int CLK_MHZ = 100;
   localparam int NEG_DLY_US = 2000;
   localparam int UV_QUAL_US = 100;
   localparam int NEG_DLY_CYC = NEG_DLY_US * CLK_MHZ;
   localparam int UV_QUAL_CYC = UV_QUAL_US * CLK_MHZ;
endpackage

/* File: common/drs_reg_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface drs_reg_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   modport slave (output addr, wdata, wr, rd, input rdata);
   modport regs (input addr, wdata, wr, rd, output rdata);
endinterface
`default_nettype wire

/* File: rtl/drs_qual_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module drs_qual_timer
   #(parameter int CYCLES = 10)
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // condition and result
   input wire logic i_cond,
   output logic o_done
);
   localparam int W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);
   logic [W-1:0] cnt;

   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst || !i_cond)
      begin
         cnt <= '0;
         o_done <= 1'b0;
      end
      else if (!o_done)
      begin
         if (cnt == LAST)
            o_done <= 1'b1;
         else
            cnt <= cnt + W'(1);
      end
   end

   AST_TMR_CLEAR:
   assert property (@(posedge i_clk_sys) disable iff (i_srst)
      !i_cond |=> !o_done)
   else $error("timer not cleared with its condition");

   AST_TMR_QUAL:
   assert property (@(posedge i_clk_sys) disable iff (i_srst)
      $rose(o_done) |-> $past(cnt) == LAST && $past(i_cond))
   else $error("timer done before full count");
endmodule
`default_nettype wire

/* File: rtl/drs_i2c_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module drs_i2c_slave
   import drs_pkg::*;
   #(parameter logic [6:0] DEV_ADDR = I2C_DEV_ADDR)
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // bus pins
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_o,
   output logic o_sda_oe_n,
   // register side
   drs_reg_if.slave rb
);
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_PTR, ST_WDAT, ST_RDAT}
      drs_i2c_st_e;
   drs_i2c_st_e st;
   logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
   logic [3:0] cnt;
   logic [7:0] sh, tx;
   logic rw, wpend, mack;
   logic start, stop, rise, fall;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_d <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_d <= 1'b1;
      end
      else
      begin
         scl_m <= i_scl;
         scl_s <= scl_m;
         scl_d <= scl_s;
         sda_m <= i_sda;
         sda_s <= sda_m;
         sda_d <= sda_s;
      end
   end

   assign start = scl_s && scl_d && sda_d && !sda_s;
   assign stop = scl_s && scl_d && !sda_d && sda_s;
   assign rise = scl_s && !scl_d;
   assign fall = !scl_s && scl_d;

   always_ff @(posedge i_clk_sys)
      o_sda_o <= 1'b0;

   // ----------------------------------------
   // byte engine
   // ----------------------------------------
   always_ff @(posedge i_clk_sys)
   begin
      rb.wr <= 1'b0;
      rb.rd <= 1'b0;
      if (i_srst)
      begin
         st <= ST_IDLE;
         cnt <= 4'h0;
         sh <= 8'h00;
         tx <= 8'h00;
         rw <= 1'b0;
         wpend <= 1'b0;
         mack <= 1'b0;
         o_sda_oe_n <= 1'b1;
         rb.addr <= 8'h00;
         rb.wdata <= 8'h00;
      end
      else if (start)
      begin
         st <= ST_ADDR;
         // clock fall after start is no bit: wraps to 0
         cnt <= 4'hF;
         o_sda_oe_n <= 1'b1;
      end
      else if (stop)
      begin
         st <= ST_IDLE;
         o_sda_oe_n <= 1'b1;
         rb.wr <= wpend;
         wpend <= 1'b0;
      end
      else if (rise && st != ST_IDLE)
      begin
         if (cnt != 4'h8)
            sh <= {sh[6:0], sda_s};
         mack <= !sda_s;
      end
      else if (fall && st != ST_IDLE)
      begin
         cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
         o_sda_oe_n <= 1'b1;
         if (cnt == 4'h7)
         begin
            case (st)
               ST_ADDR:
                  if (sh[7:1] == DEV_ADDR)
                  begin
                     o_sda_oe_n <= 1'b0;
                     rw <= sh[0];
                  end
                  else
                     st <= ST_IDLE;
               ST_PTR:
               begin
                  o_sda_oe_n <= 1'b0;
                  rb.addr <= sh;
               end
               ST_WDAT:
               begin
                  o_sda_oe_n <= 1'b0;
                  rb.wdata <= sh;
                  wpend <= 1'b1;
               end
               default:
                  o_sda_oe_n <= 1'b1;
            endcase
         end
         else if (cnt == 4'h8)
         begin
            if ((st == ST_ADDR && rw) || (st == ST_RDAT && mack))
            begin
               st <= ST_RDAT;
               tx <= rb.rdata;
               o_sda_oe_n <= rb.rdata[7];
               rb.rd <= 1'b1;
            end
            else if (st == ST_RDAT)
               st <= ST_IDLE;
            else if (st == ST_ADDR)
               st <= ST_PTR;
            else
               st <= ST_WDAT;
         end
         else if (st == ST_RDAT)
            o_sda_oe_n <= tx[3'(6 - cnt)];
      end
   end

   AST_WR_AT_STOP:
   assert property (@(posedge i_clk_sys) disable iff (i_srst)
      rb.wr |-> $past(stop) && $past(wpend))
   else $error("register write not at stop");
endmodule
`default_nettype wire

/* File: rtl/drs_top.sv */
`timescale 1ns/1ps
`default_nettype none
module drs_top
   import drs_pkg::*;
   #(
      parameter int NEG_DLY_CYCLES = NEG_DLY_CYC,
      parameter int UV_QUAL_CYCLES = UV_QUAL_CYC,
      parameter logic [6:0] DEV_ADDR = I2C_DEV_ADDR
   )
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // host pins
   input wire logic i_pos_rail_enable_pin,
   input wire logic i_neg_rail_enable_pin,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_o,
   output logic o_sda_oe_n,
   // analog indications
   input wire logic i_input_lockout,
   input wire logic i_over_temp,
   input wire logic i_boost_ss_done,
   input wire logic i_boost_rail_low,
   input wire logic i_positive_rail_low,
   input wire logic i_negative_rail_high,
   // rail controls
   output logic o_boost_rail_en,
   output logic o_positive_rail_en,
   output logic o_negative_rail_en,
   output logic o_pos_pulldown_en
);
   drs_reg_if rb();
   logic [7:0] raw, sync_m, sync_s;
   logic pos_s, neg_s, lock_s, otp_s, ss_s;
   logic [2:0] low_s;
   logic [7:0] en_reg, fault;
   logic armed, pin_clr, en_wr, fault_rd, rd_seen, otp_rd_clr;
   logic next_boost, next_pos, next_neg, neg_req, neg_dly_done;
   logic [2:0] uv_cond, uv_done, uv_hit;

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   assign raw = {i_pos_rail_enable_pin, i_neg_rail_enable_pin,
      i_input_lockout, i_over_temp, i_boost_ss_done,
      i_positive_rail_low, i_negative_rail_high, i_boost_rail_low};

   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         sync_m <= 8'h00;
         sync_s <= 8'h00;
      end
      else
      begin
         sync_m <= raw;
         sync_s <= sync_m;
      end
   end

   assign pos_s = sync_s[7];
   assign neg_s = sync_s[6];
   assign lock_s = sync_s[5];
   assign otp_s = sync_s[4];
   assign ss_s = sync_s[3];
   assign low_s = sync_s[2:0];

   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   drs_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_i2c (
      .i_clk_sys(i_clk_sys),
      .i_srst(i_srst),
      .i_scl(i_scl),
      .i_sda(i_sda),
      .o_sda_o(o_sda_o),
      .o_sda_oe_n(o_sda_oe_n),
      .rb(rb.slave)
   );

   assign en_wr = rb.wr && rb.addr == RAIL_ENABLE_CONTROL_ADDR;
   assign fault_rd = rb.rd && rb.addr == FAULT_FLAGS_ADDR;

   always_comb
   begin
      case (rb.addr)
         FAULT_FLAGS_ADDR: rb.rdata = fault;
         RAIL_ENABLE_CONTROL_ADDR: rb.rdata = en_reg;
         default: rb.rdata = 8'h00;
      endcase
   end

   // ----------------------------------------
   // enable register
   // ----------------------------------------
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
         en_reg <= RAIL_ENABLE_RST;
      else if (en_wr)
         en_reg <= rb.wdata;
   end

   // ----------------------------------------
   // pin cycle detect
   // ----------------------------------------
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
         armed <= 1'b0;
      else if (!pos_s && !neg_s)
         armed <= 1'b1;
      else if (pos_s && neg_s)
         armed <= 1'b0;
   end

   assign pin_clr = armed && pos_s && neg_s;

   // ----------------------------------------
   // rail sequencing
   // ----------------------------------------
   assign next_boost = !lock_s && !otp_s && (pos_s || neg_s)
      && en_reg[EN_BOOST] && !fault[FLT_BOOST_UV];
   assign next_pos = next_boost && ss_s && pos_s && en_reg[EN_POS]
      && !fault[FLT_POS_UV];
   assign neg_req = next_boost && ss_s && neg_s && en_reg[EN_NEG];
   assign next_neg = neg_req && neg_dly_done && !fault[FLT_NEG_UV];

   drs_qual_timer #(.CYCLES(NEG_DLY_CYCLES)) u_neg_dly (
      .i_clk_sys(i_clk_sys),
      .i_srst(i_srst),
      .i_cond(neg_req),
      .o_done(neg_dly_done)
   );

   // both pins drop the pos and neg enables on one edge
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         o_boost_rail_en <= 1'b0;
         o_positive_rail_en <= 1'b0;
         o_negative_rail_en <= 1'b0;
         o_pos_pulldown_en <= 1'b1;
      end
      else
      begin
         o_boost_rail_en <= next_boost;
         o_positive_rail_en <= next_pos;
         o_negative_rail_en <= next_neg;
         o_pos_pulldown_en <= !next_pos && !en_reg[EN_POS_HIZ];
      end
   end

   // ----------------------------------------
   // undervoltage qualification
   // ----------------------------------------
   assign uv_cond[0] = o_boost_rail_en && low_s[0] && !otp_s;
   assign uv_cond[1] = o_negative_rail_en && low_s[1] && !otp_s;
   assign uv_cond[2] = o_positive_rail_en && low_s[2] && !otp_s;

   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_uv
         drs_qual_timer #(.CYCLES(UV_QUAL_CYCLES)) u_uv (
            .i_clk_sys(i_clk_sys),
            .i_srst(i_srst),
            .i_cond(uv_cond[g]),
            .o_done(uv_done[g])
         );
      end
   endgenerate

   assign uv_hit = uv_done & {3{!otp_s}};

   // ----------------------------------------
   // fault flags
   // ----------------------------------------
   assign otp_rd_clr = fault_rd && rd_seen;

   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst || !fault[FLT_OTP])
         rd_seen <= 1'b0;
      else if (fault_rd)
         rd_seen <= !rd_seen;
   end

   // a new event wins over any clear in the same cycle
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
         fault <= FAULT_FLAGS_RST;
      else
      begin
         fault[7:4] <= 4'h0;
         fault[FLT_OTP] <= otp_s
            || (fault[FLT_OTP] && !pin_clr && !otp_rd_clr);
         fault[FLT_POS_UV:FLT_BOOST_UV] <= uv_hit
            | (fault[FLT_POS_UV:FLT_BOOST_UV] & {3{!pin_clr}});
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_srst);

   AST_OTP_ALL_OFF:
   assert property (otp_s |=> !o_boost_rail_en && !o_positive_rail_en
      && !o_negative_rail_en)
   else $error("rail left on during over-temperature");

   AST_OTP_FLAG:
   assert property (otp_s |=> fault[FLT_OTP])
   else $error("over-temperature flag not latched");

   AST_OTP_KEEPS_EN:
   assert property (otp_s && !en_wr |=> $stable(en_reg))
   else $error("enable register changed by over-temperature");

   AST_RD_TWICE:
   assert property (otp_rd_clr && !otp_s |=> !fault[FLT_OTP]
      && $stable(fault[FLT_POS_UV:FLT_BOOST_UV]))
   else $error("second read did not clear only the flag");

   AST_OTP_NO_UV:
   assert property (otp_s ##1 otp_s |->
      (fault[3:1] & ~$past(fault[3:1])) == 3'h0)
   else $error("undervoltage raised during over-temperature");

   AST_UV_CLEAR:
   assert property (pin_clr && uv_hit == 3'h0 |=> fault[3:1] == 3'h0)
   else $error("undervoltage flags not cleared by pins");

   AST_POS_START:
   assert property ($rose(o_positive_rail_en) |->
      $past(ss_s && pos_s && en_reg[EN_POS]))
   else $error("positive rail started too early");

   AST_NEG_START:
   assert property ($rose(o_negative_rail_en) |->
      $past(neg_req && neg_dly_done))
   else $error("negative rail started without delay");

   AST_POS_PIN_OFF:
   assert property ($fell(pos_s) |=> !o_positive_rail_en)
   else $error("positive rail kept after pin low");

   AST_PINS_LOW:
   assert property (!pos_s && !neg_s |=> !o_boost_rail_en
      && !o_positive_rail_en && !o_negative_rail_en)
   else $error("rails on with both pins low");

   AST_LOCKOUT:
   assert property (lock_s |=> !o_boost_rail_en
      && !o_positive_rail_en && !o_negative_rail_en)
   else $error("rails on during input lockout");

   AST_EN_AT_STOP:
   assert property (!$stable(en_reg) |-> $past(en_wr))
   else $error("enable register changed outside stop");

   AST_HIZ:
   assert property ($past(en_reg[EN_POS_HIZ]) |-> !o_pos_pulldown_en)
   else $error("pull-down connected in hi-z mode");

   COV_NEG_ON: cover property ($rose(o_negative_rail_en));
   COV_OTP: cover property ($rose(fault[FLT_OTP]));
   COV_UV: cover property ($rose(fault[FLT_POS_UV]));
endmodule
`default_nettype wire

/* File: sim/drs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module drs_host_model
   import drs_pkg::*;
(
   // clock
   input wire logic i_clk_sys,
   // bus lines
   input wire logic i_sda,
   output var logic o_scl,
   output var logic o_sda_low
);
   int ack_errs;
   initial
   begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
      ack_errs = 0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask
   // ----------------------------------------
   // bit level, 80 ns bus clock period
   // ----------------------------------------
   task automatic xfer_bit(input logic b, output logic r);
      o_scl <= 1'b0;
      tick(2);
      o_sda_low <= ~b;
      tick(2);
      o_scl <= 1'b1;
      tick(3);
      r = i_sda;
      tick(1);
   endtask
   task automatic start();
      o_scl <= 1'b0;
      tick(2);
      o_sda_low <= 1'b0;
      tick(2);
      o_scl <= 1'b1;
      tick(4);
      o_sda_low <= 1'b1;
      tick(4);
   endtask
   // bus clock idles high between frames
   task automatic stop();
      o_scl <= 1'b0;
      tick(2);
      o_sda_low <= 1'b1;
      tick(2);
      o_scl <= 1'b1;
      tick(4);
      o_sda_low <= 1'b0;
      tick(4);
   endtask
   task automatic byte_tx(input logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         xfer_bit(d[i], r);
      xfer_bit(1'b1, r);
      if (r !== 1'b0)
         ack_errs++;
   endtask
   // ----------------------------------------
   // transactions
   // ----------------------------------------
   task automatic wr_open(input logic [7:0] ptr, input logic [7:0] d);
      start();
      byte_tx({I2C_DEV_ADDR, 1'b0});
      byte_tx(ptr);
      byte_tx(d);
   endtask
   task automatic rd_reg(input logic [7:0] ptr, output logic [7:0] d);
      logic r;
      start();
      byte_tx({I2C_DEV_ADDR, 1'b0});
      byte_tx(ptr);
      start();
      byte_tx({I2C_DEV_ADDR, 1'b1});
      for (int i = 7; i >= 0; i--)
         xfer_bit(1'b1, d[i]);
      xfer_bit(1'b1, r);
      stop();
   endtask
endmodule
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import drs_pkg::*;
   localparam int NDLY = 50;
   typedef struct packed {
      logic p;
      logic n;
      logic lo;
      logic ss;
      logic eb;
      logic ep;
   } drs_row_s;
   logic clk, srst, pos_pin, neg_pin, lockout, otp, ssdone;
   logic bst_low, pos_low, neg_high;
   wire logic scl, sda_low, sda_o, sda_oe_n, sda;
   wire logic bst_en, pos_en, neg_en, pd_en;
   int miscompares, checks_done, n;
   logic [7:0] rd;
   drs_row_s rows [5] = '{
      '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0},
      '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1},
      '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0},
      '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0},
      '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0}};
   // open-drain data line with pull-up
   assign sda = ~sda_low & (sda_oe_n | sda_o);
   always #5 clk = ~clk;
   drs_top #(.NEG_DLY_CYCLES(NDLY), .UV_QUAL_CYCLES(20)) uut (
      .i_clk_sys(clk), .i_srst(srst),
      .i_pos_rail_enable_pin(pos_pin), .i_neg_rail_enable_pin(neg_pin),
      .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n),
      .i_input_lockout(lockout), .i_over_temp(otp),
      .i_boost_ss_done(ssdone), .i_boost_rail_low(bst_low),
      .i_positive_rail_low(pos_low), .i_negative_rail_high(neg_high),
      .o_boost_rail_en(bst_en), .o_positive_rail_en(pos_en),
      .o_negative_rail_en(neg_en), .o_pos_pulldown_en(pd_en));
   drs_host_model host (.i_clk_sys(clk), .i_sda(sda), .o_scl(scl),
      .o_sda_low(sda_low));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic close_out();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic cmp1(input logic g, input logic e, input string w);
      checks_done++;
      if (g !== e)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t %s got %b exp %b", $time, w, g, e);
      end
   endtask
   task automatic cmp8(input logic [7:0] p, input logic [7:0] e);
      host.rd_reg(p, rd);
      checks_done++;
      if (rd !== e)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t reg %h got %h exp %h", $time, p, rd, e);
      end
   endtask
   task automatic wr(input logic [7:0] d);
      host.wr_open(RAIL_ENABLE_CONTROL_ADDR, d);
      host.stop();
      cyc(6);
   endtask
   task automatic wait_neg();
      n = 0;
      while (neg_en !== 1'b1 && n < 200)
      begin
         cyc(1);
         n++;
      end
      if (n == 200)
      begin
         miscompares++;
         close_out();
      end
   endtask
   task automatic pins(input logic v);
      pos_pin <= v;
      neg_pin <= v;
      cyc(6);
   endtask
   // m holds {positive low, negative high, boost low}
   task automatic uv(input logic [2:0] m, input int k);
      {pos_low, neg_high, bst_low} <= m;
      cyc(k);
      {pos_low, neg_high, bst_low} <= 3'h0;
      cyc(4);
   endtask
   initial
   begin
      repeat (60000) @(posedge clk);
      miscompares++;
      close_out();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      srst = 1'b1;
      {pos_pin, neg_pin, lockout, otp, ssdone} = 5'h00;
      {bst_low, pos_low, neg_high} = 3'h0;
      miscompares = 0;
      checks_done = 0;
      cyc(6);
      srst <= 1'b0;
      cyc(1);
      cmp1(pd_en, 1'b1, "reset pulldown");
      cmp8(FAULT_FLAGS_ADDR, 8'h00);
      cmp8(RAIL_ENABLE_CONTROL_ADDR, 8'h07);
      cmp8(8'h10, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 5; i++)
      begin
         pos_pin <= rows[i].p;
         neg_pin <= rows[i].n;
         lockout <= rows[i].lo;
         ssdone <= rows[i].ss;
         cyc(6);
         cmp1(bst_en, rows[i].eb, "row boost");
         cmp1(pos_en, rows[i].ep, "row positive");
         cmp1(neg_en, 1'b0, "row negative");
      end
      $display("test rows done");
      lockout <= 1'b0;
      pins(1'b1);
      wait_neg();
      cmp1(n >= NDLY - 10 && n <= NDLY + 4, 1'b1, "neg delay");
      pos_pin <= 1'b0;
      neg_pin <= 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         cyc(1);
         cmp1(pos_en, neg_en, "tied pins off");
      end
      cmp1(bst_en, 1'b0, "boost off");
      $display("test pin sequence done");
      pins(1'b1);
      wait_neg();
      host.wr_open(RAIL_ENABLE_CONTROL_ADDR, 8'h00);
      cyc(6);
      cmp1(pos_en, 1'b1, "before stop");
      host.stop();
      cyc(6);
      cmp1(pos_en | neg_en | bst_en, 1'b0, "all off");
      cmp8(RAIL_ENABLE_CONTROL_ADDR, 8'h00);
      wr(8'h07);
      cmp1(pos_en, 1'b1, "positive first");
      cmp1(neg_en, 1'b0, "negative later");
      wait_neg();
      cmp1(n >= NDLY - 12 && n <= NDLY, 1'b1, "i2c neg delay");
      wr(8'h03);
      cmp1(pos_en, 1'b0, "pos bit off");
      cmp1(neg_en, 1'b1, "neg kept");
      cmp1(pd_en, 1'b1, "pulldown on");
      wr(8'h0B);
      cmp1(pd_en, 1'b0, "hi-z pulldown");
      wr(8'h07);
      wait_neg();
      $display("test register control done");
      otp <= 1'b1;
      cyc(5);
      cmp1(bst_en | pos_en | neg_en, 1'b0, "otp off");
      uv(3'h4, 30);
      cmp8(FAULT_FLAGS_ADDR, 8'h01);
      cmp8(RAIL_ENABLE_CONTROL_ADDR, 8'h07);
      otp <= 1'b0;
      cyc(6);
      cmp1(bst_en & pos_en, 1'b1, "otp restart");
      wait_neg();
      cmp8(FAULT_FLAGS_ADDR, 8'h01);
      cmp8(FAULT_FLAGS_ADDR, 8'h00);
      $display("test over-temp done");
      uv(3'h4, 15);
      cmp1(pos_en, 1'b1, "short glitch");
      cmp8(FAULT_FLAGS_ADDR, 8'h00);
      uv(3'h4, 30);
      cmp1(pos_en, 1'b0, "pos uv off");
      uv(3'h2, 30);
      cmp1(neg_en, 1'b0, "neg uv off");
      uv(3'h1, 30);
      cmp1(bst_en, 1'b0, "boost uv off");
      cmp8(FAULT_FLAGS_ADDR, 8'h0E);
      otp <= 1'b1;
      cyc(6);
      otp <= 1'b0;
      cyc(6);
      cmp8(FAULT_FLAGS_ADDR, 8'h0F);
      cmp8(FAULT_FLAGS_ADDR, 8'h0F);
      cmp8(FAULT_FLAGS_ADDR, 8'h0E);
      otp <= 1'b1;
      cyc(6);
      otp <= 1'b0;
      pins(1'b0);
      pins(1'b1);
      cmp8(FAULT_FLAGS_ADDR, 8'h00);
      cmp1(bst_en & pos_en, 1'b1, "rails back");
      cmp1(host.ack_errs == 0, 1'b1, "bus acks");
      $display("test faults done");
      wr(8'h08);
      otp <= 1'b1;
      cyc(6);
      otp <= 1'b0;
      srst <= 1'b1;
      cyc(6);
      srst <= 1'b0;
      cyc(1);
      cmp1(bst_en | pos_en | neg_en, 1'b0, "reset rails off");
      cmp1(pd_en, 1'b1, "reset pulldown again");
      cmp8(FAULT_FLAGS_ADDR, 8'h00);
      cmp8(RAIL_ENABLE_CONTROL_ADDR, 8'h07);
      $display("test mid-run reset done");
      close_out();
   end
endmodule
`default_nettype wire
